// File: common/cbmi_pkg.sv
// Constants, register map and carrier types for the bit timing and message interface block
package cbmi_pkg;

    localparam int          CBMI_N_SETS      = 2;
    localparam int          CBMI_N_OBJ       = 32;
    localparam int          CBMI_XFER_CYCLES = 3;

    localparam logic [7:0]  CBMI_ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  CBMI_ADDR_BTRL   = 8'h06;
    localparam logic [7:0]  CBMI_ADDR_BIT_TIMING_SEGMENTS   = 8'h07;
    localparam logic [7:0]  CBMI_ADDR_PRESCALER_EXT   = 8'h0C;
    localparam logic [2:0]  CBMI_SET1_PAGE   = 3'h1;

    localparam logic [4:0]  CBMI_OFF_CREQL   = 5'h00;
    localparam logic [4:0]  CBMI_OFF_CREQH   = 5'h01;
    localparam logic [4:0]  CBMI_OFF_CMSK    = 5'h02;
    localparam logic [4:0]  CBMI_OFF_MSK1L   = 5'h03;
    localparam logic [4:0]  CBMI_OFF_MSK1H   = 5'h04;
    localparam logic [4:0]  CBMI_OFF_MSK2L   = 5'h05;
    localparam logic [4:0]  CBMI_OFF_MSK2H   = 5'h06;
    localparam logic [4:0]  CBMI_OFF_ARB1L   = 5'h07;
    localparam logic [4:0]  CBMI_OFF_ARB1H   = 5'h08;
    localparam logic [4:0]  CBMI_OFF_ARB2L   = 5'h09;
    localparam logic [4:0]  CBMI_OFF_ARB2H   = 5'h0A;
    localparam logic [4:0]  CBMI_OFF_MCTRL   = 5'h0B;
    localparam logic [4:0]  CBMI_OFF_MCTRH   = 5'h0C;
    localparam logic [4:0]  CBMI_OFF_DATA0   = 5'h0D;
    localparam logic [4:0]  CBMI_OFF_DATA7   = 5'h14;

    localparam int          CBMI_CTRL_INIT   = 0;
    localparam int          CBMI_CTRL_CCE    = 6;
    localparam int          CBMI_CM_DIR      = 7;
    localparam int          CBMI_CM_MASK     = 6;
    localparam int          CBMI_CM_ARB      = 5;
    localparam int          CBMI_CM_CTRL     = 4;
    localparam int          CBMI_CM_CLRPND   = 3;
    localparam int          CBMI_CM_TQND     = 2;
    localparam int          CBMI_CM_DATA_LO  = 1;
    localparam int          CBMI_CM_DATA_HI  = 0;
    localparam int          CBMI_MC_NEWDATA  = 7;
    localparam int          CBMI_MC_PENDING  = 5;
    localparam int          CBMI_MC_TXREQ    = 0;

    localparam logic [7:0]  CBMI_CTRL_RST    = 8'h41;
    localparam logic [7:0]  CBMI_BTRL_RST    = 8'h01;
    localparam logic [6:0]  CBMI_BIT_TIMING_SEGMENTS_RST    = 7'h23;
    localparam logic [3:0]  CBMI_PRESCALER_EXT_RST    = 4'h0;
    localparam logic [5:0]  CBMI_CREQ_RST    = 6'h01;
    localparam logic [7:0]  CBMI_CMSK_RST    = 8'h00;
    localparam logic [5:0]  CBMI_MSG_MAX     = 6'h20;
    localparam logic [28:0] CBMI_MASK_RST    = 29'h1FFFFFFF;

    typedef struct packed {
        logic [63:0] data;
        logic [7:0]  ctrl_hi;
        logic        eob;
        logic [3:0]  dlc;
        logic        valid;
        logic        xtd;
        logic        dir;
        logic [28:0] id;
        logic        mxtd;
        logic        mdir;
        logic [28:0] mask;
    } cbmi_obj_t;

    typedef struct packed {
        logic [4:0]  seg_before_len;
        logic [3:0]  seg_after_len;
        logic [2:0]  resync_jump_len;
        logic [10:0] prescale;
    } cbmi_timing_t;

endpackage

// File: hdl/cbmi_core.sv
// Bit timing registers, quantum generator and two message interface sets with message RAM
`timescale 1ns/10ps
//
// Behaviour
// [RULE1] Segment after sample point is programmed value plus one quanta, values 0 to 7.
// [RULE2] Segment before sample point is programmed value plus one quanta, values 0 to 15.
// [RULE3] Timing registers reset to 0x01 and 0x23, giving 500 kbit/s at 8 MHz.
// [RULE4] Extension field sits above 6-bit prescaler; divider uses concatenation plus one.
// [RULE5] Extension register is written only while config change enable is set.
// [RULE6] Two identical independent interface sets; either may run while other runs.
// [RULE7] Writing message number starts transfer, sets busy, pulls wait output low.
// [RULE8] Transfer completes in 3 to 6 clocks, then busy and wait release.
// [RULE9] Number 0 means object 0x20; 0x21 to 0x3F wrap to 0x01 to 0x1F.
// [RULE10] Direction bit zero reads object into buffers, one writes buffers into object.
// [RULE11] Mask access bit moves mask, mask direction and mask extended bits.
// [RULE12] Arbitration access moves identifier, direction, extended and valid bits.
// [RULE13] Control access moves message control bits; otherwise destination unchanged.
// [RULE14] Clear-pending bit clears object pending flag on reads, ignored on writes.
// [RULE15] Write with bit 2 sets object transmit request, ignoring buffer request bit.
// [RULE16] Read with bit 2 clears object new-data flag, else it stays.
// [RULE17] Buffer receives flag values from before any clearing on the same read.
// [RULE18] Bit 1 moves data bytes 0-3, bit 0 bytes 4-7; others unchanged.
// [RULE19] Bit timing registers writable only with config change enable and init set.
// [RULE20] Time quantum is extension times 0x40 plus prescaler plus one clocks.
// [RULE21] CPU waits for busy to clear before touching that set again.
// [RULE22] Unimplemented bits of timing, extension and request registers read zero.
module cbmi_core
    import cbmi_pkg::*;
#(
    parameter int XFER_CYCLES = CBMI_XFER_CYCLES
) (
    input  wire logic                   sys_clk,
    input  wire logic                   reset_n,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    output logic                        can_wait_n,
    output logic      [CBMI_N_SETS-1:0] transfer_busy_flag,
    output logic                        tq_tick,
    output cbmi_timing_t                bit_timing
);

    localparam logic [1:0] XFER_LAST = 2'(XFER_CYCLES - 1);

    logic [7:0]   ctrl_q;
    logic [7:0]   btrl_q;
    logic [6:0]   bit_timing_segments_q;
    logic [3:0]   prescaler_ext_q;
    logic         config_change_enable;
    logic         init_mode;
    logic [9:0]   presc_raw;
    logic [9:0]   tq_cnt_q;
    logic         tq_tick_q;
    cbmi_timing_t timing_q;
    logic [7:0]   rdata_q;
    logic [7:0]   glob_rd;

    cbmi_obj_t    msg_ram_q [CBMI_N_OBJ];
    cbmi_obj_t    buf_q     [CBMI_N_SETS];
    logic [5:0]   message_number_q [CBMI_N_SETS];
    logic [7:0]   cmsk_q    [CBMI_N_SETS];
    logic [1:0]   xfer_cnt_q [CBMI_N_SETS];
    logic         busy_q    [CBMI_N_SETS];
    logic         xfer_done [CBMI_N_SETS];
    logic [4:0]   obj_idx   [CBMI_N_SETS];
    logic [7:0]   set_rd    [CBMI_N_SETS];

    assign config_change_enable = ctrl_q[CBMI_CTRL_CCE];
    assign init_mode            = ctrl_q[CBMI_CTRL_INIT];
    assign presc_raw            = {prescaler_ext_q, btrl_q[5:0]};  // [RULE4]

    // Byte view of a buffer set
    function automatic logic [7:0] get_byte(input cbmi_obj_t o, input logic [4:0] off);
        logic [7:0] b;
        b = 8'h00;
        case (off)
            CBMI_OFF_MSK1L: b = o.mask[7:0];
            CBMI_OFF_MSK1H: b = o.mask[15:8];
            CBMI_OFF_MSK2L: b = o.mask[23:16];
            CBMI_OFF_MSK2H: b = {o.mxtd, o.mdir, 1'b1, o.mask[28:24]};
            CBMI_OFF_ARB1L: b = o.id[7:0];
            CBMI_OFF_ARB1H: b = o.id[15:8];
            CBMI_OFF_ARB2L: b = o.id[23:16];
            CBMI_OFF_ARB2H: b = {o.valid, o.xtd, o.dir, o.id[28:24]};
            CBMI_OFF_MCTRL: b = {o.eob, 3'h0, o.dlc};
            CBMI_OFF_MCTRH: b = o.ctrl_hi;
            default: begin
                if (off >= CBMI_OFF_DATA0 && off <= CBMI_OFF_DATA7) begin
                    b = o.data[8 * (off - CBMI_OFF_DATA0) +: 8];
                end
            end
        endcase
        return b;
    endfunction

    function automatic cbmi_obj_t put_byte(input cbmi_obj_t o, input logic [4:0] off,
                                           input logic [7:0] v);
        cbmi_obj_t r;
        r = o;
        case (off)
            CBMI_OFF_MSK1L: r.mask[7:0] = v;
            CBMI_OFF_MSK1H: r.mask[15:8] = v;
            CBMI_OFF_MSK2L: r.mask[23:16] = v;
            CBMI_OFF_MSK2H: {r.mxtd, r.mdir, r.mask[28:24]} = {v[7:6], v[4:0]};
            CBMI_OFF_ARB1L: r.id[7:0] = v;
            CBMI_OFF_ARB1H: r.id[15:8] = v;
            CBMI_OFF_ARB2L: r.id[23:16] = v;
            CBMI_OFF_ARB2H: {r.valid, r.xtd, r.dir, r.id[28:24]} = v;
            CBMI_OFF_MCTRL: {r.eob, r.dlc} = {v[7], v[3:0]};
            CBMI_OFF_MCTRH: r.ctrl_hi = v;
            default: begin
                if (off >= CBMI_OFF_DATA0 && off <= CBMI_OFF_DATA7) begin
                    r.data[8 * (off - CBMI_OFF_DATA0) +: 8] = v;
                end
            end
        endcase
        return r;
    endfunction
    // Control register: init and config change enable
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= CBMI_CTRL_RST;
        end else if (reg_wr && reg_addr == CBMI_ADDR_CTRL) begin
            ctrl_q <= reg_wdata & 8'h41;
        end
    end
    // Bit timing registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            btrl_q <= CBMI_BTRL_RST;  // [RULE3]
            bit_timing_segments_q <= CBMI_BIT_TIMING_SEGMENTS_RST;  // [RULE3]
        end else if (reg_wr && config_change_enable && init_mode) begin  // [RULE19]
            if (reg_addr == CBMI_ADDR_BTRL) begin
                btrl_q <= reg_wdata;
            end
            if (reg_addr == CBMI_ADDR_BIT_TIMING_SEGMENTS) begin
                bit_timing_segments_q <= reg_wdata[6:0];  // [RULE22]
            end
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescaler_ext_q <= CBMI_PRESCALER_EXT_RST;
        end else if (reg_wr && config_change_enable && reg_addr == CBMI_ADDR_PRESCALER_EXT) begin // [RULE5]
            prescaler_ext_q <= reg_wdata[3:0];  // [RULE22]
        end
    end
    // Decoded segment lengths for the protocol core
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timing_q <= '0;
        end else begin
            timing_q.seg_before_len  <= {1'b0, bit_timing_segments_q[3:0]} + 5'h01;  // [RULE2]
            timing_q.seg_after_len   <= {1'b0, bit_timing_segments_q[6:4]} + 4'h1;   // [RULE1]
            timing_q.resync_jump_len <= {1'b0, btrl_q[7:6]} + 3'h1;
            timing_q.prescale        <= {1'b0, presc_raw} + 11'h001;  // [RULE4]
        end
    end

    // Quantum generator: one tick every presc_raw+1 clocks
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tq_cnt_q  <= '0;
            tq_tick_q <= 1'b0;
        end else begin
            tq_tick_q <= (tq_cnt_q >= presc_raw);  // [RULE20]
            if (tq_cnt_q >= presc_raw) begin
                tq_cnt_q <= '0;
            end else begin
                tq_cnt_q <= tq_cnt_q + 10'h001;
            end
        end
    end

    // Per-set command, buffer and transfer sequencing
    for (genvar s = 0; s < CBMI_N_SETS; s++) begin : g_set  // [RULE6]
        logic       hit;
        logic       wr_s;
        logic [4:0] off;
        logic [5:0] fixed_num;
        logic [7:0] cm;
        cbmi_obj_t  obj;

        assign hit  = (reg_addr[7:5] == 3'(CBMI_SET1_PAGE + 3'(s)));
        assign wr_s = reg_wr && hit;
        assign off  = reg_addr[4:0];
        assign cm   = cmsk_q[s];
        assign obj  = msg_ram_q[obj_idx[s]];

        always_comb begin
            if (reg_wdata[5:0] == 6'h00) begin
                fixed_num = CBMI_MSG_MAX;  // [RULE9]
            end else if (reg_wdata[5:0] > CBMI_MSG_MAX) begin
                fixed_num = {1'b0, reg_wdata[4:0]};  // [RULE9]
            end else begin
                fixed_num = reg_wdata[5:0];
            end
        end

        assign obj_idx[s]   = 5'(message_number_q[s] - 6'h01);
        assign xfer_done[s] = busy_q[s] && xfer_cnt_q[s] == XFER_LAST;  // [RULE8]

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                message_number_q[s] <= CBMI_CREQ_RST;
                busy_q[s]           <= 1'b0;
                xfer_cnt_q[s]       <= '0;
            end else if (wr_s && off == CBMI_OFF_CREQL) begin
                message_number_q[s] <= fixed_num;
                busy_q[s]           <= 1'b1;  // [RULE7]
                xfer_cnt_q[s]       <= '0;
            end else if (xfer_done[s]) begin
                busy_q[s]           <= 1'b0;  // [RULE8]
            end else if (busy_q[s]) begin
                xfer_cnt_q[s]       <= xfer_cnt_q[s] + 2'h1;
            end
        end

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                cmsk_q[s] <= CBMI_CMSK_RST;
            end else if (wr_s && off == CBMI_OFF_CMSK) begin
                cmsk_q[s] <= reg_wdata;
            end
        end

        // Read transfers fill the buffer; they win over a CPU write in the same cycle
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                buf_q[s]      <= '0;
                buf_q[s].mask <= CBMI_MASK_RST;
                buf_q[s].mdir <= 1'b1;
                buf_q[s].mxtd <= 1'b1;
            end else if (xfer_done[s] && !cm[CBMI_CM_DIR]) begin  // [RULE10]
                if (cm[CBMI_CM_MASK]) begin  // [RULE11]
                    {buf_q[s].mxtd, buf_q[s].mdir, buf_q[s].mask} <=
                        {obj.mxtd, obj.mdir, obj.mask};
                end
                if (cm[CBMI_CM_ARB]) begin  // [RULE12]
                    {buf_q[s].valid, buf_q[s].xtd, buf_q[s].dir, buf_q[s].id} <=
                        {obj.valid, obj.xtd, obj.dir, obj.id};
                end
                if (cm[CBMI_CM_CTRL]) begin  // [RULE13]
                    buf_q[s].eob     <= obj.eob;
                    buf_q[s].dlc     <= obj.dlc;
                    buf_q[s].ctrl_hi <= obj.ctrl_hi;  // [RULE17]
                end
                if (cm[CBMI_CM_DATA_LO]) begin  // [RULE18]
                    buf_q[s].data[31:0] <= obj.data[31:0];
                end
                if (cm[CBMI_CM_DATA_HI]) begin  // [RULE18]
                    buf_q[s].data[63:32] <= obj.data[63:32];
                end
            end else if (wr_s && off >= CBMI_OFF_MSK1L) begin
                buf_q[s] <= put_byte(buf_q[s], off, reg_wdata);
            end
        end

        always_comb begin
            case (off)
                CBMI_OFF_CREQL: set_rd[s] = {2'b00, message_number_q[s]};  // [RULE22]
                CBMI_OFF_CREQH: set_rd[s] = {busy_q[s], 7'h00};            // [RULE22]
                CBMI_OFF_CMSK:  set_rd[s] = cmsk_q[s];
                default:        set_rd[s] = get_byte(buf_q[s], off);
            endcase
        end
    end

    // Message RAM; set two is applied after set one when both finish together
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < CBMI_N_OBJ; i++) begin
                msg_ram_q[i] <= '0;
            end
        end else begin
            for (int s = 0; s < CBMI_N_SETS; s++) begin
                if (xfer_done[s] && cmsk_q[s][CBMI_CM_DIR]) begin  // [RULE10]
                    if (cmsk_q[s][CBMI_CM_MASK]) begin  // [RULE11]
                        msg_ram_q[obj_idx[s]].mask <= buf_q[s].mask;
                        msg_ram_q[obj_idx[s]].mdir <= buf_q[s].mdir;
                        msg_ram_q[obj_idx[s]].mxtd <= buf_q[s].mxtd;
                    end
                    if (cmsk_q[s][CBMI_CM_ARB]) begin  // [RULE12]
                        msg_ram_q[obj_idx[s]].id    <= buf_q[s].id;
                        msg_ram_q[obj_idx[s]].dir   <= buf_q[s].dir;
                        msg_ram_q[obj_idx[s]].xtd   <= buf_q[s].xtd;
                        msg_ram_q[obj_idx[s]].valid <= buf_q[s].valid;
                    end
                    if (cmsk_q[s][CBMI_CM_CTRL]) begin  // [RULE13]
                        msg_ram_q[obj_idx[s]].eob     <= buf_q[s].eob;
                        msg_ram_q[obj_idx[s]].dlc     <= buf_q[s].dlc;
                        msg_ram_q[obj_idx[s]].ctrl_hi <= buf_q[s].ctrl_hi;
                    end
                    if (cmsk_q[s][CBMI_CM_TQND]) begin  // [RULE15]
                        msg_ram_q[obj_idx[s]].ctrl_hi[CBMI_MC_TXREQ] <= 1'b1;
                    end
                    if (cmsk_q[s][CBMI_CM_DATA_LO]) begin  // [RULE18]
                        msg_ram_q[obj_idx[s]].data[31:0] <= buf_q[s].data[31:0];
                    end
                    if (cmsk_q[s][CBMI_CM_DATA_HI]) begin  // [RULE18]
                        msg_ram_q[obj_idx[s]].data[63:32] <= buf_q[s].data[63:32];
                    end
                end else if (xfer_done[s]) begin
                    if (cmsk_q[s][CBMI_CM_CLRPND]) begin  // [RULE14]
                        msg_ram_q[obj_idx[s]].ctrl_hi[CBMI_MC_PENDING] <= 1'b0;
                    end
                    if (cmsk_q[s][CBMI_CM_TQND]) begin  // [RULE16]
                        msg_ram_q[obj_idx[s]].ctrl_hi[CBMI_MC_NEWDATA] <= 1'b0;
                    end
                end
            end
        end
    end

    // Register read port
    always_comb begin
        case (reg_addr)
            CBMI_ADDR_CTRL: glob_rd = ctrl_q;
            CBMI_ADDR_BTRL: glob_rd = btrl_q;
            CBMI_ADDR_BIT_TIMING_SEGMENTS: glob_rd = {1'b0, bit_timing_segments_q};           // [RULE22]
            CBMI_ADDR_PRESCALER_EXT: glob_rd = {4'h0, prescaler_ext_q};  // [RULE22]
            default:
                glob_rd = (reg_addr[7:5] == CBMI_SET1_PAGE)        ? set_rd[0] :
                          (reg_addr[7:5] == CBMI_SET1_PAGE + 3'h1) ? set_rd[1] : 8'h00;
        endcase
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? glob_rd : 8'h00;
        end
    end
    assign reg_rdata             = rdata_q;
    assign can_wait_n            = !(busy_q[0] || busy_q[1]);  // [RULE7]
    assign transfer_busy_flag    = {busy_q[1], busy_q[0]};
    assign tq_tick               = tq_tick_q;
    assign bit_timing            = timing_q;
    // Helper for quantum spacing check
    logic [10:0] tq_gap_q;
    logic        tq_seen_q;
    logic        tq_cfg_chg_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tq_gap_q     <= 11'h001;
            tq_seen_q    <= 1'b0;
            tq_cfg_chg_q <= 1'b0;
        end else begin
            tq_gap_q     <= tq_tick_q ? 11'h001 : tq_gap_q + 11'h001;
            tq_seen_q    <= tq_seen_q || tq_tick_q;
            tq_cfg_chg_q <= (reg_wr && (reg_addr == CBMI_ADDR_BTRL || reg_addr == CBMI_ADDR_PRESCALER_EXT))
                            || (tq_cfg_chg_q && !tq_tick_q);
        end
    end

    a_busy_length: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [RULE8]
        $rose(busy_q[0]) && !(reg_wr && reg_addr == 8'h20) |->
            busy_q[0] [*3] ##1 !busy_q[0])
        else $error("set one busy not three cycles");
    a_creq_start: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [RULE7]
        reg_wr && reg_addr == 8'h40 |=> busy_q[1] && !can_wait_n)
        else $error("request write did not start transfer");
    a_msgnum_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [RULE9]
        reg_wr && reg_addr == 8'h20 && reg_wdata[5:0] == 6'h00 |=>
            message_number_q[0] == 6'h20)
        else $error("message number zero not mapped to 0x20");
    a_msgnum_wrap: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [RULE9]
        reg_wr && reg_addr == 8'h20 && reg_wdata[5:0] > 6'h20 |=>
            message_number_q[0] == $past(reg_wdata[5:0]) - 6'h20)
        else $error("message number above 0x20 not wrapped");
    a_ext_locked: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [RULE5]
        reg_wr && reg_addr == 8'h0C && !ctrl_q[6] |=> $stable(prescaler_ext_q))
        else $error("extension written without enable");
    a_btr_locked: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [RULE19]
        reg_wr && reg_addr == 8'h07 && !(ctrl_q[6] && ctrl_q[0]) |=> $stable(bit_timing_segments_q))
        else $error("timing register written while locked");
    a_tq_spacing: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [RULE20]
        tq_tick_q && tq_seen_q && !tq_cfg_chg_q |->
            tq_gap_q == {1'b0, prescaler_ext_q, btrl_q[5:0]} + 11'h001)
        else $error("quantum spacing wrong");
    // Sampled reset guard skips the release edge, where the decode is still cleared
    a_seg_lengths: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [RULE1]
        reset_n |=> timing_q.seg_after_len == {1'b0, $past(bit_timing_segments_q[6:4])} + 4'h1
            && timing_q.seg_before_len == {1'b0, $past(bit_timing_segments_q[3:0])} + 5'h01)
        else $error("segment length not value plus one");
    a_newdata_clr: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [RULE16]
        xfer_done[1] && !cmsk_q[1][7] && cmsk_q[1][2] |=>
            !msg_ram_q[$past(obj_idx[1])].ctrl_hi[7])
        else $error("new data flag not cleared on read");
    a_txreq_set: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [RULE15]
        xfer_done[0] && cmsk_q[0][7] && cmsk_q[0][2] && !xfer_done[1] |=>
            msg_ram_q[$past(obj_idx[0])].ctrl_hi[0])
        else $error("transmit request not set on write");
endmodule

// File: verif/cbmi_cpu.sv
// Host CPU model driving the block's register port
`timescale 1ns/10ps
module cbmi_cpu (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // Strobe rises after one edge, drops after the next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for bit timing and message interface sets
`timescale 1ns/10ps
module tb_top
    import cbmi_pkg::*;
;
    logic         sys_clk = 1'b0;
    logic         reset_n = 1'b0;
    logic   [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic         reg_wr, reg_rd, can_wait_n, tq_tick;
    logic  [15:0] seg_pair;
    logic   [1:0] transfer_busy_flag;
    cbmi_timing_t bit_timing;
    int           fails = 0;
    int           tests_run = 0;
    int           nb;

    always #12.5 sys_clk = ~sys_clk;

    assign seg_pair = {7'h00, bit_timing.seg_before_len, bit_timing.seg_after_len};

    cbmi_core #(.XFER_CYCLES(CBMI_XFER_CYCLES)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .can_wait_n(can_wait_n),
        .transfer_busy_flag(transfer_busy_flag), .tq_tick(tq_tick), .bit_timing(bit_timing));
    cbmi_cpu cpu (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    task automatic wrap_up();
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        cpu.rd(a, rv);
        chk(nm, {8'h00, rv}, {8'h00, exp});
    endtask

    // Start a transfer, then count cycles of busy with wait low
    task automatic xfer(input int s, input logic [7:0] cmd, input logic [7:0] msg);
        logic [7:0] base;
        base = (s == 0) ? 8'h20 : 8'h40;
        nb   = 0;
        cpu.wr(base + 8'h02, cmd);
        cpu.wr(base, msg);
        repeat (8) begin
            @(negedge sys_clk);
            if (transfer_busy_flag[s] === 1'b1 && can_wait_n === 1'b0) nb++;
        end
        chk("busy_len", nb[15:0], CBMI_XFER_CYCLES[15:0]);
    endtask

    // Cycles from one quantum tick to the next, bounded
    task automatic tq_period(input logic [15:0] exp);
        int n;
        n = 0;
        while (tq_tick !== 1'b1 && n < 600) begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (tq_tick !== 1'b1 && n < 600);
        chk("tq_period", n[15:0], exp);
    endtask

    initial begin
        #2000000;
        fails++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        rchk("btrl", CBMI_ADDR_BTRL, 8'h01);
        rchk("bit_timing_segments", CBMI_ADDR_BIT_TIMING_SEGMENTS, 8'h23);
        chk("seg", seg_pair, 16'h0043);
        chk("pre", {5'h00, bit_timing.prescale}, 16'h0002);
        cpu.wr(CBMI_ADDR_BIT_TIMING_SEGMENTS, 8'hFF);
        cpu.wr(CBMI_ADDR_BTRL, 8'h3F);
        cpu.wr(CBMI_ADDR_PRESCALER_EXT, 8'hFF);
        rchk("bit_timing_segments_unimp", CBMI_ADDR_BIT_TIMING_SEGMENTS, 8'h7F);
        rchk("prescaler_ext_unimp", CBMI_ADDR_PRESCALER_EXT, 8'h0F);
        chk("seg_max", seg_pair, 16'h0108);
        chk("pre_max", {5'h00, bit_timing.prescale}, 16'h0400);
        cpu.wr(CBMI_ADDR_CTRL, 8'h40);
        cpu.wr(CBMI_ADDR_BIT_TIMING_SEGMENTS, 8'h12);
        cpu.wr(CBMI_ADDR_PRESCALER_EXT, 8'h03);
        rchk("bit_timing_segments_lock", CBMI_ADDR_BIT_TIMING_SEGMENTS, 8'h7F);
        rchk("prescaler_ext_cce", CBMI_ADDR_PRESCALER_EXT, 8'h03);
        cpu.wr(CBMI_ADDR_CTRL, 8'h00);
        cpu.wr(CBMI_ADDR_PRESCALER_EXT, 8'h05);
        rchk("prescaler_ext_lock", CBMI_ADDR_PRESCALER_EXT, 8'h03);
        tq_period(16'h0100);
        rchk("unmapped", 8'hFF, 8'h00);
        cpu.wr(8'h2D, 8'hA5);
        cpu.wr(8'h31, 8'h5A);
        cpu.wr(8'h2A, 8'h80);
        xfer(0, 8'hA7, 8'h00);
        rchk("msg_zero", 8'h20, 8'h20);
        xfer(1, 8'h3E, 8'h20);
        rchk("data_lo", 8'h4D, 8'hA5);
        rchk("data_hi", 8'h51, 8'h00);
        rchk("arb", 8'h4A, 8'h80);
        rchk("txreq", 8'h4C, 8'h01);
        rchk("mask", 8'h46, 8'hFF);
        cpu.wr(8'h2C, 8'hA0);
        xfer(0, 8'h90, 8'h20);
        xfer(1, 8'h1C, 8'h20);
        rchk("flags_pre", 8'h4C, 8'hA0);
        xfer(1, 8'h10, 8'h20);
        rchk("flags_clr", 8'h4C, 8'h00);
        xfer(1, 8'h40, 8'h20);
        rchk("mask_rd", 8'h46, 8'h20);
        xfer(1, 8'h00, 8'h3F);
        rchk("msg_wrap", 8'h40, 8'h1F);
        wrap_up();
    end
endmodule
